/* dv/crc_engine_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_defines.vh"

// Bus timing and engine status checks at the register block's ports.
module crc_engine_checker #(
	parameter ADDR_W = 13
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Register bus.
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Engine status.
	input wire logic engine_enabled,
	input wire logic engine_busy
);
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Each request waits exactly one cycle.
	AST_FIRST_WAIT: assert property ((read || write) && !$past(read || write) |-> waitrequest)
		else $error("request answered without a wait cycle");
	AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait cycle");
	// Reset must be checked while reset is low, so it has no disable.
	AST_RESET: assert property (disable iff (1'b0) !reset_n |=> !engine_enabled && !engine_busy && readdata == 32'h0)
		else $error("state not cleared by reset");
	AST_ENABLE_WRITE: assert property (write && !waitrequest && address == `IDX_MAIN_CONTROL && byteenable[0] |=> engine_enabled == $past(writedata[7]))
		else $error("enable does not follow control write");
	// A disabled engine drops any pending word by the next edge.
	AST_DISABLED_IDLE: assert property (!engine_enabled |=> !engine_busy)
		else $error("engine busy while disabled");
	AST_WORD_PENDING: assert property (engine_enabled && write && !waitrequest && address == `IDX_INPUT_WORD && byteenable[0] |=> engine_busy [*2])
		else $error("input word write did not make engine busy");
	AST_BUSY_CAUSE: assert property ($rose(engine_busy) |-> $past(write && !waitrequest && address == `IDX_INPUT_WORD))
		else $error("busy rose without an input word");
	AST_READ_STABLE: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("read data changed without a read");
	AST_UNMAPPED: assert property (read && !waitrequest && !(address inside {`IDX_INPUT_WORD, `IDX_RESULT_WINDOW, `IDX_MAIN_CONTROL, `IDX_POLY_LENGTH, `IDX_WORD_LENGTH}) |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_READ: assert property (read && !waitrequest && address == `IDX_MAIN_CONTROL |-> readdata[7] == $past(engine_enabled) && readdata[5] == $past(engine_busy))
		else $error("control read disagrees with status");
endmodule // crc_engine_checker

bind crc_engine_regs crc_engine_checker #(.ADDR_W(ADDR_W)) i_crc_engine_checker (.core_clk, .reset_n,
	.address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .engine_enabled,
	.engine_busy);

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_defines.vh"

module testbench;
	localparam logic [12:0] word_adr = `IDX_INPUT_WORD;
	localparam logic [12:0] res_adr = `IDX_RESULT_WINDOW;
	localparam logic [12:0] ctl_adr = `IDX_MAIN_CONTROL;
	// Bench-driven inputs and observed outputs.
	logic core_clk = 1'h0;
	logic reset_n = 1'h0;
	logic [12:0] address = 13'h0;
	logic read = 1'h0;
	logic write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic engine_enabled;
	logic engine_busy;
	logic [31:0] rv;
	int miscompares = 0;
	int checks_done = 0;

	crc_engine_regs i_crc_engine_regs (.core_clk, .reset_n, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .engine_enabled, .engine_busy);

	// Free-running clock.
	initial forever #2.5 core_clk = ~core_clk;

	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One bus cycle; the edge first keeps a new request off the previous release.
	task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 50);
		if (n >= 50) miscompares++;
		rv = readdata;
		read <= 1'h0;
		write <= 1'h0;
	endtask

	// Poll control until busy drops, bounded so a stuck engine shows as a mismatch.
	task automatic poll;
		int k;
		k = 0;
		do begin
			bus(1'h0, ctl_adr, 32'h0, 4'hF);
			k++;
		end while (rv[5] !== 1'h0 && k < 40);
		// A busy flag that never drops is a failure, not a silent exit.
		if (rv[5] !== 1'h0) miscompares++;
	endtask

	task automatic t_reset;
		logic [12:0] adrs [6];
		adrs = '{word_adr, res_adr, ctl_adr, `IDX_POLY_LENGTH, `IDX_WORD_LENGTH, 13'h0100};
		chk("enabled", engine_enabled, 1'h0);
		foreach (adrs[i]) begin
			bus(1'h0, adrs[i], 32'h0, 4'hF);
			chk("reset value", rv, 32'h0);
		end
		bus(1'h1, word_adr, 32'h11223344, 4'hF);
		bus(1'h1, word_adr, 32'hAABBCCDD, 4'h5);
		bus(1'h0, word_adr, 32'h0, 4'hF);
		chk("input lanes", rv, 32'h11BB33DD);
	endtask

	task automatic t_overlay;
		bus(1'h1, ctl_adr, 32'h08, 4'h1);
		bus(1'h1, res_adr, 32'hA5A5A5A5, 4'hF);
		bus(1'h1, ctl_adr, 32'h00, 4'h1);
		bus(1'h1, res_adr, 32'h12345678, 4'hF);
		bus(1'h1, res_adr, 32'h0000AB00, 4'h2);
		bus(1'h1, ctl_adr, 32'h04, 4'h1);
		bus(1'h1, res_adr, 32'hFFFFFFFF, 4'hF);
		bus(1'h0, res_adr, 32'h0, 4'hF);
		chk("shifter view", rv, 32'h0);
		bus(1'h1, ctl_adr, 32'h0C, 4'h1);
		bus(1'h0, res_adr, 32'h0, 4'hF);
		chk("result alias", rv, 32'h1234AB78);
		bus(1'h1, ctl_adr, 32'h08, 4'h1);
		bus(1'h0, res_adr, 32'h0, 4'hF);
		chk("taps", rv, 32'hA5A5A5A5);
	endtask

	// CRC-8 over words of 8, 12, 16 and 20 bits, one length per direction and augment mode pair.
	task automatic t_crc;
		logic [31:0] acc;
		logic [31:0] w;
		logic [4:0] dl;
		logic b;
		logic fb;
		w = 32'hC3A55A3C;
		for (int m = 0; m < 4; m++) begin
			dl = 5'(7 + 4 * m);
			bus(1'h1, `IDX_POLY_LENGTH, 32'h07, 4'h1);
			bus(1'h1, `IDX_WORD_LENGTH, {27'h0, dl}, 4'h1);
			bus(1'h1, ctl_adr, 32'h88, 4'h1);
			bus(1'h1, res_adr, 32'h07, 4'hF);
			bus(1'h1, ctl_adr, {24'h0, 3'h6, m[1], 2'h0, m[0], 1'h0}, 4'h1);
			poll;
			bus(1'h1, res_adr, 32'h5A, 4'hF);
			bus(1'h1, word_adr, w, 4'hF);
			#1;
			chk("busy", engine_busy, 1'h1);
			poll;
			chk("done flags", {rv[5], rv[0]}, 2'h0);
			bus(1'h0, res_adr, 32'h0, 4'hF);
			acc = 32'h5A;
			for (int i = 0; i <= dl; i++) begin
				b = m[0] ? w[i] : w[dl - i];
				// Right mode runs the accumulator right and feeds back from its bit 0.
				if (m[0]) begin
					fb = m[1] ? acc[0] : b ^ acc[0];
					acc = (acc >> 1) | {24'h0, m[1] & b, 7'h0};
				end else begin
					fb = m[1] ? acc[7] : b ^ acc[7];
					acc = (acc << 1) | {31'h0, m[1] & b};
				end
				acc = (acc ^ (fb ? 32'h07 : 32'h0)) & 32'hFF;
			end
			chk("crc", rv, acc);
		end
	endtask

	// A word waits while start is clear, and disabling discards it.
	task automatic t_hold;
		bus(1'h1, ctl_adr, 32'h80, 4'h1);
		bus(1'h1, word_adr, 32'h0F0F0F0F, 4'hF);
		repeat (20) @(posedge core_clk);
		bus(1'h0, ctl_adr, 32'h0, 4'hF);
		chk("pending flags", rv[7:0], 8'hA1);
		bus(1'h1, ctl_adr, 32'hC0, 4'h1);
		poll;
		chk("drained", rv[7:0], 8'hC0);
		bus(1'h1, ctl_adr, 32'h80, 4'h1);
		bus(1'h1, word_adr, 32'h0F0F0F0F, 4'hF);
		bus(1'h1, ctl_adr, 32'h00, 4'h1);
		// The pending flag clears at the edge after enable falls.
		@(posedge core_clk);
		#1;
		chk("disabled", {engine_enabled, engine_busy}, 2'h0);
		bus(1'h1, ctl_adr, 32'hFF, 4'h1);
		bus(1'h0, ctl_adr, 32'h0, 4'hF);
		chk("control bits", rv[7:0], 8'hDE);
	endtask

	// The window shows the live shifter: the loaded word, then three left shifts later.
	task automatic t_view;
		bus(1'h1, `IDX_WORD_LENGTH, 32'h1F, 4'h1);
		bus(1'h1, ctl_adr, 32'hC4, 4'h1);
		bus(1'h1, word_adr, 32'h0F0F0F0F, 4'hF);
		bus(1'h0, res_adr, 32'h0, 4'hF);
		chk("shifter loaded", rv, 32'h0F0F0F0F);
		bus(1'h0, res_adr, 32'h0, 4'hF);
		chk("shifter live", rv, 32'h78787878);
		poll;
		bus(1'h0, res_adr, 32'h0, 4'hF);
		chk("shifter drained", rv, 32'h0);
	endtask

	// Main sequence.
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'h1;
		t_reset;
		t_overlay;
		t_crc;
		t_hold;
		t_view;
		report_and_stop;
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#100000;
		miscompares++;
		report_and_stop;
	end
endmodule // testbench

`default_nettype wire

/* logic/crc_engine_defines.vh */
`ifndef CRC_ENGINE_DEFINES_VH
`define CRC_ENGINE_DEFINES_VH

// Register indexes; the byte address of each register is four times its index.
`define IDX_INPUT_WORD 13'h1C9A
`define IDX_RESULT_WINDOW 13'h1C9E
`define IDX_MAIN_CONTROL 13'h1CA2
`define IDX_POLY_LENGTH 13'h1CA3
`define IDX_WORD_LENGTH 13'h1CA4

// Main control bit positions.
`define CTL_ENABLE 7
`define CTL_START 6
`define CTL_BUSY 5
`define CTL_AUGMENT 4
`define CTL_OVERLAY_HI 3
`define CTL_OVERLAY_LO 2
`define CTL_SHIFT_DIR 1
`define CTL_FULL 0

// Overlay selector codes.
`define OVL_RESULT_A 2'h0
`define OVL_SHIFTER 2'h1
`define OVL_TAPS 2'h2
`define OVL_RESULT_B 2'h3

// Reset values.
`define RST_WORD32 32'h00000000
`define RST_LEN5 5'h00
`define RST_BIT 1'h0
`define RST_OVERLAY 2'h0

// Cycles from the start of a request to the cycle that ends it.
`define BUS_ANSWER_CYCLES 1

`endif

/* logic/crc_engine_regs.v */
// Functional notes
// - Clear enable holds the shifter and full flag in reset, the accumulator keeps its value; set enable runs it.
// - Start set runs the serial shifter; start clear stops it.
// - Busy reads one while shifting is in progress or a word is pending.
// - Augment bit set shifts data through the accumulator and appends no zeros itself; clear processes data without augmentation.
// - Overlay selector: 00 and 11 result, 01 shifter view, 10 taps.
// - Direction bit one shifts right LSB first; zero shifts left MSB first.
// - Full flag reads one while the input word waits to be taken.
// - Polynomial length minus one sizes the active accumulator.
// - Word length minus one plus one bits are shifted per word.
// - Input word is 32 bits, four read/write bytes, resetting to zero.
// - Result bytes write and read the accumulator directly.
// - Shifter view is read-only and returns the live shifter bytes.
// - Result and shifter view share one address, chosen by overlay.
// - Tap register bits enable feedback of matching polynomial terms.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crc_engine_defines.vh"

module crc_engine_regs #(
	parameter DATA_W = 32,
	parameter LEN_W = 5,
	parameter ADDR_W = 13
) (
	// Clock and reset.
	input wire core_clk,
	input wire reset_n,
	// Avalon-MM slave, word addressed.
	input wire [ADDR_W-1:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	// Engine state for neighbouring logic.
	output wire engine_enabled,
	output wire engine_busy
);

	// Bus handshake state.
	reg ack_q;
	wire req;
	wire wr_fire;
	wire rd_take;

	// Control fields.
	reg enable_q;
	reg start_q;
	reg zero_augment_select_q;
	reg [1:0] overlay_q;
	reg shift_direction_q;
	reg full_q;
	reg [LEN_W-1:0] polynomial_length_minus_one_q;
	reg [LEN_W-1:0] word_length_minus_one_q;

	// Data holding registers.
	reg [DATA_W-1:0] checksum_input_word_q;
	reg [DATA_W-1:0] polynomial_tap_enables_q;

	// Engine connections.
	wire [DATA_W-1:0] shifter_word;
	wire [DATA_W-1:0] acc_word;
	wire shifter_empty;
	wire take_word;
	wire busy;
	wire acc_wr;
	wire [DATA_W-1:0] acc_wdata;
	wire [7:0] main_control;

	// Address hits.
	wire hit_input;
	wire hit_window;
	wire hit_main;
	wire hit_polynomial_length_minus_one;
	wire hit_word_length_minus_one;
	wire sel_result;
	wire sel_shifter;
	wire sel_taps;

	// Byte-lane merge used by every 32-bit register that software writes.
	function [31:0] merge_bytes;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] lanes;
		integer b;
		begin
			merge_bytes = old_word;
			for (b = 0; b < 4; b = b + 1) begin
				if (lanes[b]) begin
					merge_bytes[8*b +: 8] = new_word[8*b +: 8];
				end
			end
		end
	endfunction

	// Every request waits one cycle so read data come from a flip-flop.
	// The cost is one extra cycle per access; the gain is a clean timing path.
	assign req = read | write;
	assign waitrequest = req & ~ack_q;
	assign wr_fire = write & ack_q;
	assign rd_take = read & ~ack_q;

	// The acknowledge toggles so back-to-back requests each get their cycle.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Address decode.
	assign hit_input = (address == `IDX_INPUT_WORD);
	assign hit_window = (address == `IDX_RESULT_WINDOW);
	assign hit_main = (address == `IDX_MAIN_CONTROL);
	assign hit_polynomial_length_minus_one = (address == `IDX_POLY_LENGTH);
	assign hit_word_length_minus_one = (address == `IDX_WORD_LENGTH);

	// Overlay steering of the shared window.
	assign sel_result = (overlay_q == `OVL_RESULT_A) | (overlay_q == `OVL_RESULT_B);
	assign sel_shifter = (overlay_q == `OVL_SHIFTER);
	assign sel_taps = (overlay_q == `OVL_TAPS);

	// Status terms.
	assign busy = full_q | ~shifter_empty;
	assign take_word = enable_q & start_q & full_q & shifter_empty;
	assign engine_enabled = enable_q;
	assign engine_busy = busy;

	// Assembled main control byte as software sees it.
	assign main_control = {
		enable_q,
		start_q,
		busy,
		zero_augment_select_q,
		overlay_q,
		shift_direction_q,
		full_q
	};

	// Main control writes; busy and full are read-only and ignore writes.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			enable_q <= `RST_BIT;
			start_q <= `RST_BIT;
			zero_augment_select_q <= `RST_BIT;
			overlay_q <= `RST_OVERLAY;
			shift_direction_q <= `RST_BIT;
		end else if (wr_fire && hit_main && byteenable[0]) begin
			enable_q <= writedata[`CTL_ENABLE];
			start_q <= writedata[`CTL_START];
			zero_augment_select_q <= writedata[`CTL_AUGMENT];
			overlay_q <= writedata[`CTL_OVERLAY_HI:`CTL_OVERLAY_LO];
			shift_direction_q <= writedata[`CTL_SHIFT_DIR];
		end
	end

	// Length fields live in the low five bits of their byte.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			polynomial_length_minus_one_q <= `RST_LEN5;
			word_length_minus_one_q <= `RST_LEN5;
		end else if (wr_fire && byteenable[0]) begin
			if (hit_polynomial_length_minus_one) begin
				polynomial_length_minus_one_q <= writedata[LEN_W-1:0];
			end
			if (hit_word_length_minus_one) begin
				word_length_minus_one_q <= writedata[LEN_W-1:0];
			end
		end
	end

	// Input word, written byte by byte from any lane.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			checksum_input_word_q <= `RST_WORD32;
		end else if (wr_fire && hit_input) begin
			checksum_input_word_q <= merge_bytes(checksum_input_word_q, writedata, byteenable);
		end
	end

	// Full flag: a write holding the low lane completes the word.
	// A completing write in the same cycle as a transfer keeps the flag set,
	// so the newly written word is never lost.
	always @(posedge core_clk) begin
		if (!reset_n || !enable_q) begin
			full_q <= 1'b0;
		end else if (wr_fire && hit_input && byteenable[0]) begin
			full_q <= 1'b1;
		end else if (take_word) begin
			full_q <= 1'b0;
		end
	end

	// Tap register, reached through the overlay window only.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			polynomial_tap_enables_q <= `RST_WORD32;
		end else if (wr_fire && hit_window && sel_taps) begin
			polynomial_tap_enables_q <= merge_bytes(polynomial_tap_enables_q, writedata, byteenable);
		end
	end

	// Direct accumulator writes; the shifter view drops writes silently.
	assign acc_wr = wr_fire & hit_window & sel_result;
	assign acc_wdata = merge_bytes(acc_word, writedata, byteenable);

	// Shifter and accumulator engine.
	crc_shift_core #(
		.W(DATA_W),
		.LW(LEN_W)
	) u_core (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.hold_in_reset(~enable_q),
		.run(start_q),
		.load(take_word),
		.load_word(checksum_input_word_q),
		.word_len_m1(word_length_minus_one_q),
		.poly_len_m1(polynomial_length_minus_one_q),
		.shift_right(shift_direction_q),
		.augment(zero_augment_select_q),
		.taps(polynomial_tap_enables_q),
		.acc_wr(acc_wr),
		.acc_wdata(acc_wdata),
		.shifter_q(shifter_word),
		.acc_q(acc_word),
		.empty(shifter_empty)
	);

	// Read data are captured in the waiting cycle and stand at the answer.
	// Unmapped addresses answer normally with zero.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			readdata <= 32'h00000000;
		end else if (rd_take) begin
			if (hit_input) begin
				readdata <= checksum_input_word_q;
			end else if (hit_window && sel_result) begin
				readdata <= acc_word;
			end else if (hit_window && sel_shifter) begin
				readdata <= shifter_word;
			end else if (hit_window) begin
				readdata <= polynomial_tap_enables_q;
			end else if (hit_main) begin
				readdata <= {24'h000000, main_control};
			end else if (hit_polynomial_length_minus_one) begin
				readdata <= {27'h0000000, polynomial_length_minus_one_q};
			end else if (hit_word_length_minus_one) begin
				readdata <= {27'h0000000, word_length_minus_one_q};
			end else begin
				readdata <= 32'h00000000;
			end
		end
	end

endmodule // crc_engine_regs

`default_nettype wire

/* logic/crc_shift_core.v */
`timescale 1ns/1ps
`default_nettype none

// Serial shifter and linear feedback accumulator, one data bit per clock.
module crc_shift_core #(
	parameter W = 32,
	parameter LW = 5
) (
	// Clock and reset.
	input wire core_clk,
	input wire reset_n,
	// Control from the register file.
	input wire hold_in_reset,
	input wire run,
	input wire load,
	input wire [W-1:0] load_word,
	input wire [LW-1:0] word_len_m1,
	input wire [LW-1:0] poly_len_m1,
	input wire shift_right,
	input wire augment,
	input wire [W-1:0] taps,
	// Direct accumulator load.
	input wire acc_wr,
	input wire [W-1:0] acc_wdata,
	// State.
	output reg [W-1:0] shifter_q,
	output reg [W-1:0] acc_q,
	output wire empty
);

	reg [LW:0] bits_q;
	reg [W-1:0] acc_d;
	reg [W-1:0] poly_mask;
	reg din;
	reg fb;
	wire step;
	integer i;

	assign step = run & (bits_q != {(LW+1){1'b0}});
	assign empty = (bits_q == {(LW+1){1'b0}});

	// Next accumulator value for one incoming bit; taps pick the feedback terms.
	always @* begin
		poly_mask = {W{1'b0}};
		for (i = 0; i < W; i = i + 1) begin
			poly_mask[i] = (i <= poly_len_m1);
		end
		if (shift_right) begin
			din = shifter_q[0];
			fb = augment ? acc_q[0] : (acc_q[0] ^ din);
			acc_d = acc_q >> 1;
			if (augment) begin
				acc_d[poly_len_m1] = din;
			end
		end else begin
			din = shifter_q[word_len_m1];
			fb = augment ? acc_q[poly_len_m1] : (acc_q[poly_len_m1] ^ din);
			acc_d = augment ? ((acc_q << 1) | {{(W-1){1'b0}}, din}) : (acc_q << 1);
		end
		if (fb) begin
			acc_d = acc_d ^ taps;
		end
		acc_d = acc_d & poly_mask;
	end

	// The counter says how many valid bits the shifter still holds.
	always @(posedge core_clk) begin
		if (!reset_n || hold_in_reset) begin
			shifter_q <= {W{1'b0}};
			bits_q <= {(LW+1){1'b0}};
		end else if (load) begin
			shifter_q <= load_word;
			bits_q <= {1'b0, word_len_m1} + {{LW{1'b0}}, 1'b1};
		end else if (step) begin
			shifter_q <= shift_right ? (shifter_q >> 1) : (shifter_q << 1);
			bits_q <= bits_q - {{LW{1'b0}}, 1'b1};
		end
	end

	// Software writes win over a shift step in the same cycle.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			acc_q <= {W{1'b0}};
		end else if (acc_wr) begin
			acc_q <= acc_wdata;
		end else if (step && !hold_in_reset) begin
			acc_q <= acc_d;
		end
	end

endmodule // crc_shift_core

`default_nettype wire
